// file: tb/ppsl_props.sv
// ppsl_props.sv: port checks for the slot power block
// assumes CORE_IDX 0, bound onto the block
`timescale 1ns/1ps
module ppsl_props #(
  parameter NCORE = 4
) (
  input logic             clk,
  input logic             reset_n,
  input logic             reg_wr,
  input logic [7:0]       reg_addr,
  input logic [31:0]      reg_wdata,
  input logic             msg_valid,
  input logic             msg_ready,
  input logic [7:0]       msg_power_value,
  input logic [1:0]       msg_power_scale,
  input logic             link_down,
  input logic             cpl_pending,
  input logic             cpl_timeout_flush,
  input logic             iommu_disabled,
  input logic [NCORE-1:0] core_unused,
  input logic [NCORE-1:0] perm_tx_clk_en,
  input logic [NCORE-1:0] perm_link_clk_en,
  input logic             regs_locked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire wr_slot = reg_wr && reg_addr == 8'h6c;
  msg_start_a: assert property (wr_slot && !regs_locked && perm_tx_clk_en[0] |=> msg_valid &&
    msg_power_value == $past(reg_wdata[14:7]) && msg_power_scale == $past(reg_wdata[16:15])) else $error("bad msg");
  msg_hold_a: assert property (msg_valid && !msg_ready |=> msg_valid) else $error("msg lost");
  msg_drop_a: assert property (msg_valid && msg_ready && !reg_wr |=> !msg_valid) else $error("msg twice");
  lock_quiet_a: assert property (regs_locked && !msg_valid |=> !msg_valid) else $error("locked msg");
  lock_stick_a: assert property (regs_locked |=> regs_locked) else $error("lock lost");
  flush_cause_a: assert property (cpl_timeout_flush |-> $past(link_down) &&
    !$past(link_down, 2) && $past(cpl_pending)) else $error("bad flush");
  flush_pulse_a: assert property (cpl_timeout_flush |=> !cpl_timeout_flush) else $error("long flush");
  shared_link_a: assert property (!(iommu_disabled && core_unused[0] && core_unused[1] && core_unused[3])
    |=> perm_link_clk_en[0]) else $error("shared branch off");
endmodule // ppsl_props
bind ppsl_port_slot_power ppsl_props #(.NCORE(NCORE)) ppsl_props_inst (.clk(clk), .reset_n(reset_n),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .msg_valid(msg_valid), .msg_ready(msg_ready),
  .msg_power_value(msg_power_value), .msg_power_scale(msg_power_scale), .link_down(link_down),
  .cpl_pending(cpl_pending), .cpl_timeout_flush(cpl_timeout_flush), .iommu_disabled(iommu_disabled),
  .core_unused(core_unused), .perm_tx_clk_en(perm_tx_clk_en), .perm_link_clk_en(perm_link_clk_en),
  .regs_locked(regs_locked));

// file: tb/ppsl_sink.sv
// ppsl_sink.sv: adapter side taking power limit messages
// assumes the block's ready/valid message port
`timescale 1ns/1ps
module ppsl_sink (
  input  wire       clk,
  input  wire       slow,
  input  wire       msg_valid,
  input  wire [7:0] msg_power_value,
  input  wire [1:0] msg_power_scale,
  output reg        msg_ready = 0,
  output reg  [9:0] last_msg = 0,
  output integer    num_msg = 0
);
  reg [1:0] wait_r = 0;
  // take one message, late when slow
  always @(posedge clk) begin
    if (msg_valid && msg_ready) begin
      num_msg <= num_msg + 1;
      last_msg <= {msg_power_scale, msg_power_value};
    end
    wait_r <= msg_valid ? wait_r + 2'h1 : 2'h0;
    msg_ready <= msg_valid && !msg_ready && (!slow || wait_r == 2'h2);
  end
endmodule // ppsl_sink

// file: tb/tb.sv
// tb.sv: self-checking bench for the slot power block
// assumes the sink model and the bound checker
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t %h %h", $time, a, b); end end
module tb;
  reg         clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, link_down = 0, cpl_pending = 0, iommu_disabled = 0, slow = 0;
  reg  [7:0]  reg_addr = 8'h0;
  reg  [31:0] reg_wdata = 32'h0;
  reg  [3:0]  core_unused = 4'h0;
  wire [31:0] reg_rdata;
  wire        msg_valid, msg_ready, flush, hide, locked;
  wire [7:0]  pv;
  wire [1:0]  ps;
  wire [3:0]  ptx, dtx, plk, dlk;
  wire [9:0]  last_msg;
  wire [15:0] clk_en = {ptx, dtx, plk, dlk};
  wire [1:0]  stat = {locked, hide};
  integer     num_msg, num_errors = 0, cmp_count = 0, cyc = 0, n, s;
  ppsl_port_slot_power ppsl_port_slot_power_inst (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .msg_valid(msg_valid), .msg_ready(msg_ready),
    .msg_power_value(pv), .msg_power_scale(ps), .link_down(link_down), .cpl_pending(cpl_pending),
    .cpl_timeout_flush(flush), .iommu_disabled(iommu_disabled), .core_unused(core_unused), .perm_tx_clk_en(ptx),
    .dyn_tx_clk_en(dtx), .perm_link_clk_en(plk), .dyn_link_clk_en(dlk), .hide_gfx_cap(hide), .regs_locked(locked));
  ppsl_sink ppsl_sink_inst (.clk(clk), .slow(slow), .msg_valid(msg_valid), .msg_power_value(pv),
    .msg_power_scale(ps), .msg_ready(msg_ready), .last_msg(last_msg), .num_msg(num_msg));
  task close_out; begin
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  end endtask
  task tick(input integer k); begin repeat (k) @(posedge clk); #1; end endtask
  // strobes drop and an edge passes before the next call raises them again
  task wr(input [7:0] a, input [31:0] d); begin
    reg_wr = 1; reg_addr = a; reg_wdata = d; tick(1); reg_wr = 0; tick(1);
  end endtask
  task rd(input [7:0] a, input [31:0] e); begin
    reg_rd = 1; reg_addr = a; tick(1); reg_rd = 0;
    `CHK(reg_rdata, e)
    tick(1);
  end endtask
  // one message with payload e, none after
  task msg(input [9:0] e); integer w; begin
    n = num_msg; w = 0;
    while (num_msg == n && w < 20) begin tick(1); w++; end
    tick(4);
    `CHK(num_msg - n, 1)
    `CHK(last_msg, e)
  end endtask
  // link drop with completions pending
  task fl(input integer e); begin
    link_down = 0; tick(1); cpl_pending = 1; link_down = 1; n = 0;
    repeat (3) begin tick(1); n += flush; end
    `CHK(n, e)
  end endtask
  task t_reset; begin
    rd(8'h00, 32'h0);
    rd(8'h6c, 32'h0);
    rd(8'h70, 32'h0008_0000);
    rd(8'h10, 32'h0);
  end endtask
  task t_slot; reg [7:0] v; begin
    for (s = 0; s < 4; s++) begin
      v = 8'h3c + s[7:0]; slow = s[0];
      wr(8'h6c, {15'h7fff, s[1:0], v, 7'h7f});
      msg({s[1:0], v});
      rd(8'h6c, {15'h0, s[1:0], v, 7'h0});
    end
    slow = 1; wr(8'h6c, 32'had00); wr(8'h6c, 32'h1_5280);
    msg(10'h2a5);
  end endtask
  task t_clk; begin
    fl(1); wr(8'h70, 32'h0); fl(0);
    core_unused = 4'hf;
    wr(8'h74, 32'h4321); tick(1);
    `CHK(clk_en, 16'ha97f)
    wr(8'h74, 32'hf); tick(1);
    `CHK(clk_en, 16'heefe)
    wr(8'h6c, 32'h1ff80); rd(8'h6c, 32'h0);
    `CHK(msg_valid, 1'b0)
    iommu_disabled = 1; core_unused = 4'hb; tick(2);
    `CHK(plk[0], 1'b0)
    wr(8'h74, 32'h0); iommu_disabled = 0; core_unused = 4'h0; tick(1);
  end endtask
  task t_lock; begin
    wr(8'h00, 32'h3); tick(1);
    `CHK(stat, 2'b11)
    wr(8'h6c, 32'h0); tick(2);
    `CHK(msg_valid, 1'b0)
    rd(8'h6c, 32'h1_5280);
    wr(8'h00, 32'h0); rd(8'h00, 32'h2);
  end endtask
  // reset in mid-run with the link held down, then bring the port back up
  task t_again; begin
    reset_n = 0; tick(2); reset_n = 1; n = 0;
    repeat (3) begin tick(1); n += flush; end
    `CHK(n, 0)
    `CHK(clk_en, 16'hffff)
    `CHK(msg_valid, 1'b0)
    rd(8'h00, 32'h0);
    rd(8'h70, 32'h0008_0000);
    wr(8'h6c, 32'h0500);
    msg(10'h00a);
    wr(8'h6c, 32'h2580);
    msg(10'h04b);
    wr(8'h70, 32'h0); core_unused = 4'h4;
    wr(8'h74, 32'h0f00); tick(1);
    `CHK(clk_en, 16'hbbbb)
    rd(8'h6c, 32'h2580);
  end endtask
  initial forever #4 clk = ~clk;
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin num_errors++; close_out; end
  end
  initial begin
    tick(2); reset_n = 1;
    t_reset; t_slot; t_clk; t_lock; t_again;
    close_out;
  end
endmodule // tb

// file: verilog/ppsl_defs.vh
// ppsl_defs.vh: offsets, field positions, reset values for the port slot power and lock block
// assumes inclusion by the single design module only
`ifndef PPSL_DEFS_VH
`define PPSL_DEFS_VH

// register offsets on the configuration access port
`define PPSL_OFS_NB_MISC_CONTROL   8'h00
`define PPSL_OFS_SLOT_CAPABILITY   8'h6c
`define PPSL_OFS_PORT_RX_CONTROL   8'h70
`define PPSL_OFS_CLOCK_FORCE_OFF   8'h74

// misc control fields
`define PPSL_MISC_HIDE_GFX_BIT     0
`define PPSL_MISC_LOCK_BIT         1

// slot capability fields
`define PPSL_SLOT_VALUE_MSB        14
`define PPSL_SLOT_VALUE_LSB        7
`define PPSL_SLOT_SCALE_MSB        16
`define PPSL_SLOT_SCALE_LSB        15

// receive control fields
`define PPSL_RX_CPL_TO_MODE_BIT    19

// clock force-off layout: core c uses bits 4c+3..4c
`define PPSL_CLK_PERM_TX           0
`define PPSL_CLK_DYN_TX            1
`define PPSL_CLK_PERM_LINK         2
`define PPSL_CLK_DYN_LINK          3

// reset values
`define PPSL_RST_NB_MISC_CONTROL   32'h0000_0000
`define PPSL_RST_SLOT_CAPABILITY   32'h0000_0000
`define PPSL_RST_PORT_RX_CONTROL   32'h0008_0000
`define PPSL_RST_CLOCK_FORCE_OFF   16'h0000

`endif

// file: verilog/ppsl_port_slot_power.v
// ppsl_port_slot_power.v: root-port register bank for slot power limit, completion
// timeout mode, register lock and per-core clock branch gating.
// assumes a single-cycle register access port and a ready/valid message receiver downstream.
// assumes link status and completion inputs are synchronous to clk.
//
// Functional notes
// - slot capability bits 14:7 hold the eight-bit slot power value.
// - bits 16:15 hold the power scale, 0..3 meaning 1.0 down to 0.001.
// - every accepted slot capability write raises a power limit message; writes while one waits fold into it.
// - receive control bit 19 set times out completions at once on link down.
// - lock bit makes hardware-initialised registers ignore writes.
// - four cores each get permanent and dynamic transmit and link branches, each forceable off.
// - core one permanent link branch gated only with IOMMU off, cores one two four unused.
// - with the core's branches forced off, its port registers ignore accesses.
`timescale 1ns/1ps
`include "ppsl_defs.vh"

module ppsl_port_slot_power #(
  parameter CORE_IDX = 0,
  parameter NCORE    = 4
) (
  input  wire                 clk,
  input  wire                 reset_n,
  // register access port
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  input  wire [7:0]           reg_addr,
  input  wire [31:0]          reg_wdata,
  output reg  [31:0]          reg_rdata,
  // power limit message towards the link
  output reg                  msg_valid,
  input  wire                 msg_ready,
  output reg  [7:0]           msg_power_value,
  output reg  [1:0]           msg_power_scale,
  // completion timeout on link loss
  input  wire                 link_down,
  input  wire                 cpl_pending,
  output reg                  cpl_timeout_flush,
  // clock branch control per core
  input  wire                 iommu_disabled,
  input  wire [NCORE-1:0]     core_unused,
  output reg  [NCORE-1:0]     perm_tx_clk_en,
  output reg  [NCORE-1:0]     dyn_tx_clk_en,
  output reg  [NCORE-1:0]     perm_link_clk_en,
  output reg  [NCORE-1:0]     dyn_link_clk_en,
  // status mirrors of the misc control bits
  output reg                  hide_gfx_cap,
  output reg                  regs_locked
);

  // register map, byte offsets on the access port:
  //   0x00 misc control: bit 0 hides the graphics port capability,
  //        bit 1 locks the hardware-initialised registers until reset
  //   0x6c slot capability: bits 14:7 power value, bits 16:15 power scale
  //   0x70 receive control: bit 19 picks immediate completion timeout on link down
  //   0x74 clock force-off: four bits per core, low end first:
  //        permanent tx, dynamic tx, permanent link, dynamic link
  // slot capability and receive control ignore accesses while this core is dead;
  // misc control sits outside the port, so a dead core does not block it
  // every other bit reads zero; unmapped offsets read zero and drop writes

  // stored registers
  reg  [31:0]          misc_ctl_r;
  reg  [31:0]          slot_capability_r;
  reg  [31:0]          rx_ctl_r;
  reg  [4*NCORE-1:0]   clk_off_r;
  reg                  link_down_d_r;

  // next-state values and decoded conditions
  reg  [31:0]          slot_capability_nxt;
  reg  [31:0]          rdata_nxt;
  wire                 lock;
  wire                 core_dead;
  wire                 cap_wr;
  wire                 shared_ok;
  // loop index for the per-core enables
  integer              i;

  // one force-off bit of core c, branch b
  function off_bit;
    input [4*NCORE-1:0] v;
    input integer       c;
    input integer       b;
    begin
      off_bit = v[4*c+b];
    end
  endfunction

  // lock state straight from the misc control register
  assign lock      = misc_ctl_r[`PPSL_MISC_LOCK_BIT];
  // this port's core counts as dead once all its branches are forced off
  assign core_dead = &clk_off_r[4*CORE_IDX +: 4];
  // shared core-one permanent link branch may only stop under these conditions
  assign shared_ok = iommu_disabled & core_unused[0] & core_unused[1] & core_unused[NCORE-1];
  // slot capability is hardware-initialised: lock and dead core block it
  assign cap_wr    = reg_wr & (reg_addr == `PPSL_OFS_SLOT_CAPABILITY) & ~lock & ~core_dead;

  // next slot capability: only value and scale fields are writable
  // other bits keep their reset value of zero
  always @* begin
    slot_capability_nxt = slot_capability_r;
    slot_capability_nxt[`PPSL_SLOT_VALUE_MSB:`PPSL_SLOT_VALUE_LSB] =
      reg_wdata[`PPSL_SLOT_VALUE_MSB:`PPSL_SLOT_VALUE_LSB];
    slot_capability_nxt[`PPSL_SLOT_SCALE_MSB:`PPSL_SLOT_SCALE_LSB] =
      reg_wdata[`PPSL_SLOT_SCALE_MSB:`PPSL_SLOT_SCALE_LSB];
  end

  // register writes; the lock bit only ever sets here, reset alone clears it,
  // so a locked bank cannot be unlocked by a stray write
  always @(posedge clk) begin
    if (!reset_n) begin
      misc_ctl_r <= `PPSL_RST_NB_MISC_CONTROL;
      slot_capability_r <= `PPSL_RST_SLOT_CAPABILITY;
      rx_ctl_r   <= `PPSL_RST_PORT_RX_CONTROL;
      clk_off_r  <= {NCORE{4'h0}};
    end else if (reg_wr) begin
      case (reg_addr)
        `PPSL_OFS_NB_MISC_CONTROL: begin
          misc_ctl_r[`PPSL_MISC_HIDE_GFX_BIT] <= reg_wdata[`PPSL_MISC_HIDE_GFX_BIT];
          misc_ctl_r[`PPSL_MISC_LOCK_BIT]     <= reg_wdata[`PPSL_MISC_LOCK_BIT] | lock;
        end
        `PPSL_OFS_SLOT_CAPABILITY: begin
          if (cap_wr)
            slot_capability_r <= slot_capability_nxt;
        end
        `PPSL_OFS_PORT_RX_CONTROL: begin
          if (!core_dead)
            rx_ctl_r[`PPSL_RX_CPL_TO_MODE_BIT] <= reg_wdata[`PPSL_RX_CPL_TO_MODE_BIT];
        end
        `PPSL_OFS_CLOCK_FORCE_OFF: begin
          clk_off_r <= reg_wdata[4*NCORE-1:0];
        end
        default: begin
          misc_ctl_r <= misc_ctl_r;
        end
      endcase
    end
  end

  // read data: port registers read zero while their core is dead
  // the force-off register stays reachable, so a dead core can be revived
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (reg_addr)
      `PPSL_OFS_NB_MISC_CONTROL: rdata_nxt = misc_ctl_r;
      `PPSL_OFS_SLOT_CAPABILITY: rdata_nxt = core_dead ? 32'h0000_0000 : slot_capability_r;
      `PPSL_OFS_PORT_RX_CONTROL: rdata_nxt = core_dead ? 32'h0000_0000 : rx_ctl_r;
      `PPSL_OFS_CLOCK_FORCE_OFF: rdata_nxt[4*NCORE-1:0] = clk_off_r;
      default:                   rdata_nxt = 32'h0000_0000;
    endcase
  end

  // read data register: loads on a read strobe, holds until the next one
  always @(posedge clk) begin
    if (!reset_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
  end

  // power limit message: raised on each accepted write, payload follows latest write
  // a write while a message waits folds into it, so the far side never sees
  // a stale value paired with a fresh scale; a write in the accept cycle wins
  always @(posedge clk) begin
    if (!reset_n) begin
      msg_valid       <= 1'b0;
      msg_power_value <= 8'h00;
      msg_power_scale <= 2'h0;
    end else if (cap_wr) begin
      msg_valid       <= 1'b1;
      msg_power_value <= slot_capability_nxt[`PPSL_SLOT_VALUE_MSB:`PPSL_SLOT_VALUE_LSB];
      msg_power_scale <= slot_capability_nxt[`PPSL_SLOT_SCALE_MSB:`PPSL_SLOT_SCALE_LSB];
    end else if (msg_ready) begin
      msg_valid       <= 1'b0;
    end
  end

  // completion timeout on the rising edge of link down
  // the delayed copy follows the pin through reset too, so a link that is
  // already down when reset lifts is not taken for a fresh drop
  always @(posedge clk) begin
    if (!reset_n) begin
      link_down_d_r     <= link_down;
      cpl_timeout_flush <= 1'b0;
    end else begin
      link_down_d_r     <= link_down;
      cpl_timeout_flush <= link_down & ~link_down_d_r & cpl_pending &
                           rx_ctl_r[`PPSL_RX_CPL_TO_MODE_BIT];
    end
  end

  // clock branch enables and status outputs
  // enables lag the force-off register by one cycle; the shared core-one
  // permanent link branch ignores its force-off bit while anyone still needs it
  always @(posedge clk) begin
    if (!reset_n) begin
      perm_tx_clk_en   <= {NCORE{1'b1}};
      dyn_tx_clk_en    <= {NCORE{1'b1}};
      perm_link_clk_en <= {NCORE{1'b1}};
      dyn_link_clk_en  <= {NCORE{1'b1}};
      hide_gfx_cap     <= 1'b0;
      regs_locked      <= 1'b0;
    end else begin
      for (i = 0; i < NCORE; i = i + 1) begin
        perm_tx_clk_en[i]   <= ~off_bit(clk_off_r, i, `PPSL_CLK_PERM_TX);
        dyn_tx_clk_en[i]    <= ~off_bit(clk_off_r, i, `PPSL_CLK_DYN_TX);
        dyn_link_clk_en[i]  <= ~off_bit(clk_off_r, i, `PPSL_CLK_DYN_LINK);
        perm_link_clk_en[i] <= ~off_bit(clk_off_r, i, `PPSL_CLK_PERM_LINK);
      end
      if (off_bit(clk_off_r, 0, `PPSL_CLK_PERM_LINK) && !shared_ok)
        perm_link_clk_en[0] <= 1'b1;
      hide_gfx_cap <= misc_ctl_r[`PPSL_MISC_HIDE_GFX_BIT];
      regs_locked  <= lock;
    end
  end

endmodule // ppsl_port_slot_power
